//--- src/eeprom_front_pkg.sv
// Shared constants for the serial EEPROM command front end
package eeprom_front_pkg;
  // Operation codes of the first byte
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_RD_ARRAY = 8'h03;
  localparam logic [7:0] OP_WR_ARRAY = 8'h02;
  // Status register layout
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP0 = 2;
  localparam int ST_BP1 = 3;
  localparam int ST_PIN_EN = 7;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] STATUS_WR_MASK = 8'h8C;
  // Serial framing
  localparam int BYTE_W = 8;
  localparam int ADDR_BITS = 16;
  localparam int ARRAY_ADDR_W = 13;
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_W = 4;
  // Self-timed write cycle
  localparam int T_WC_MS = 10;
  localparam int CLK_FREQ_KHZ = 50000;
  localparam int WC_CYCLES = T_WC_MS * CLK_FREQ_KHZ;
  // Frame phases
  typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_WDATA, PH_SDATA, PH_RDATA, PH_SOUT, PH_IDLE} phase_e;
endpackage

//--- src/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      pin_out <= RST_VAL;
    end else begin
      meta_q <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule // pin_sync

//--- src/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("byte_fifo: DEPTH must be a power of two >= 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire empty = (wr_ptr_q == rd_ptr_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;

  // Handshake flags
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr_q[AW-1:0]];

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end
endmodule // byte_fifo

//--- src/spi_eeprom_front.sv
// SPI slave command front end of a serial EEPROM
`timescale 1ns/100ps
module spi_eeprom_front #(
  parameter int WRITE_CYCLES = eeprom_front_pkg::WC_CYCLES,
  parameter int ADDR_W = eeprom_front_pkg::ARRAY_ADDR_W,
  parameter int FIFO_DEPTH = eeprom_front_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic wp_n,
  output logic so_out,
  output logic so_oe_n,
  output logic rd_req,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic [7:0] wr_data,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic prog_start,
  output logic [ADDR_W-1:0] prog_addr,
  output logic busy,
  output logic write_latch,
  output logic [7:0] status,
  output logic standby,
  output logic overrun
);
  initial begin
    if (WRITE_CYCLES < 2) $error("spi_eeprom_front: WRITE_CYCLES must be at least 2");
    if (ADDR_W < 1 || ADDR_W > eeprom_front_pkg::ADDR_BITS) $error("spi_eeprom_front: ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection
  logic s_sck, s_cs_n, s_si, s_wp_n, sck_prev_q, cs_prev_q;
  pin_sync #(.W(eeprom_front_pkg::SYNC_W), .RST_VAL(4'hA)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .pin_in({cs_n, sck, wp_n, si}),
    .pin_out({s_cs_n, s_sck, s_wp_n, s_si})
  );

  // Previous levels for edge finding
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= s_sck;
      cs_prev_q <= s_cs_n;
    end
  end

  wire cs_fall = !s_cs_n && cs_prev_q;
  wire cs_rise = s_cs_n && !cs_prev_q;
  wire sck_rise = s_sck && !sck_prev_q && !s_cs_n && !cs_fall;
  wire sck_fall = !s_sck && sck_prev_q && !s_cs_n && !cs_fall;

  ////////////////////////////////////////////////////////////////////////
  // Frame state and decode
  eeprom_front_pkg::phase_e phase_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_in_q, op_q, stat_new_q, stat_nv_q;
  logic acc_q, addr_hi_done_q, stat_got_q, wr_bytes_q, wp_abort_q, busy_q, wel_q;
  logic [eeprom_front_pkg::ADDR_BITS-1:0] addr_q;
  wire [7:0] rx_byte = {shift_in_q[6:0], s_si};
  wire byte_done = sck_rise && (bit_cnt_q == 3'h7);
  wire in_opcode = (phase_q == eeprom_front_pkg::PH_OPCODE);
  wire [7:0] status_now = {stat_nv_q[7:2], wel_q, busy_q};
  wire wp_block = stat_nv_q[eeprom_front_pkg::ST_PIN_EN] && !s_wp_n;

  // Opcode to phase map
  function automatic eeprom_front_pkg::phase_e op_phase(input logic [7:0] op, input logic bsy);
    if (bsy && op != eeprom_front_pkg::OP_RD_STATUS) return eeprom_front_pkg::PH_IDLE;
    case (op)
      eeprom_front_pkg::OP_RD_STATUS: return eeprom_front_pkg::PH_SOUT;
      eeprom_front_pkg::OP_WR_STATUS: return eeprom_front_pkg::PH_SDATA;
      eeprom_front_pkg::OP_RD_ARRAY, eeprom_front_pkg::OP_WR_ARRAY: return eeprom_front_pkg::PH_ADDR;
      default: return eeprom_front_pkg::PH_IDLE;
    endcase
  endfunction

  // Accepted means one of the six codes, honoured under current busy state
  function automatic logic op_known(input logic [7:0] op, input logic bsy);
    if (bsy) return op == eeprom_front_pkg::OP_RD_STATUS;
    return op == eeprom_front_pkg::OP_SET_WEL || op == eeprom_front_pkg::OP_CLR_WEL
        || op == eeprom_front_pkg::OP_RD_STATUS || op == eeprom_front_pkg::OP_WR_STATUS
        || op == eeprom_front_pkg::OP_RD_ARRAY || op == eeprom_front_pkg::OP_WR_ARRAY;
  endfunction

  // Bit counter and input shifter, counter restarted by select falling
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 3'h0;
      shift_in_q <= 8'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_in_q <= rx_byte;
    end
  end

  // Phase sequencing
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      phase_q <= eeprom_front_pkg::PH_IDLE;
      op_q <= 8'h00;
      acc_q <= 1'b0;
      addr_hi_done_q <= 1'b0;
    end else if (cs_fall) begin
      phase_q <= eeprom_front_pkg::PH_OPCODE;
      acc_q <= 1'b0;
      addr_hi_done_q <= 1'b0;
    end else if (byte_done) begin
      case (phase_q)
        eeprom_front_pkg::PH_OPCODE: begin
          op_q <= rx_byte;
          acc_q <= op_known(rx_byte, busy_q);
          phase_q <= op_phase(rx_byte, busy_q);
        end
        eeprom_front_pkg::PH_ADDR: begin
          addr_hi_done_q <= 1'b1;
          if (addr_hi_done_q) begin
            phase_q <= (op_q == eeprom_front_pkg::OP_RD_ARRAY) ? eeprom_front_pkg::PH_RDATA
                                                               : eeprom_front_pkg::PH_WDATA;
          end
        end
        eeprom_front_pkg::PH_SDATA: phase_q <= eeprom_front_pkg::PH_IDLE;
        default: phase_q <= phase_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address, data capture and protect tracking
  wire addr_last = byte_done && phase_q == eeprom_front_pkg::PH_ADDR && addr_hi_done_q;
  wire rd_next = addr_last && op_q == eeprom_front_pkg::OP_RD_ARRAY
              || byte_done && phase_q == eeprom_front_pkg::PH_RDATA;
  wire wdata_byte = byte_done && phase_q == eeprom_front_pkg::PH_WDATA && wel_q;
  wire fifo_in_ready;
  logic rd_req_q, overrun_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_q <= '0;
      stat_new_q <= 8'h00;
      stat_got_q <= 1'b0;
      wr_bytes_q <= 1'b0;
      wp_abort_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (cs_fall) begin
      stat_got_q <= 1'b0;
      wr_bytes_q <= 1'b0;
      wp_abort_q <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      if (sck_rise && phase_q == eeprom_front_pkg::PH_ADDR) addr_q <= {addr_q[14:0], s_si};
      if (byte_done && phase_q == eeprom_front_pkg::PH_RDATA) addr_q <= addr_q + 16'h0001;
      if (byte_done && phase_q == eeprom_front_pkg::PH_SDATA) begin
        stat_new_q <= rx_byte;
        stat_got_q <= 1'b1;
      end
      if (wdata_byte && fifo_in_ready) wr_bytes_q <= 1'b1;
      if (wdata_byte && !fifo_in_ready) overrun_q <= 1'b1;
      if (!s_cs_n && op_q == eeprom_front_pkg::OP_WR_STATUS && acc_q && wp_block) wp_abort_q <= 1'b1;
    end
  end

  // Read fetch request, one pulse per byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) rd_req_q <= 1'b0;
    else rd_req_q <= rd_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output shifter, driven on falling clock only
  logic [7:0] tx_q;
  logic so_q, oe_n_q;
  wire out_phase = phase_q == eeprom_front_pkg::PH_SOUT || phase_q == eeprom_front_pkg::PH_RDATA;
  wire load_status = byte_done && (in_opcode && op_phase(rx_byte, busy_q) == eeprom_front_pkg::PH_SOUT
                                   || phase_q == eeprom_front_pkg::PH_SOUT);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_q <= 8'h00;
      so_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (s_cs_n) begin
      oe_n_q <= 1'b1;
    end else if (load_status) begin
      tx_q <= status_now;
    end else if (rd_req_q) begin
      tx_q <= rd_data;
    end else if (sck_fall && out_phase) begin
      so_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
      oe_n_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latch, self-timed write cycle and status commit
  localparam int CW = $clog2(WRITE_CYCLES);
  logic [CW-1:0] wc_cnt_q;
  logic stat_pend_q, prog_q;
  logic [ADDR_W-1:0] prog_addr_q;
  wire end_ok = cs_rise && acc_q && !busy_q;
  wire go_array = end_ok && op_q == eeprom_front_pkg::OP_WR_ARRAY && wel_q && wr_bytes_q;
  wire go_status = end_ok && op_q == eeprom_front_pkg::OP_WR_STATUS && wel_q && stat_got_q
                   && !wp_abort_q && !wp_block;
  wire launch = go_array || go_status;
  wire wc_done = busy_q && wc_cnt_q == '0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      wc_cnt_q <= '0;
      stat_pend_q <= 1'b0;
      prog_q <= 1'b0;
      prog_addr_q <= '0;
    end else begin
      prog_q <= go_array;
      if (launch) begin
        busy_q <= 1'b1;
        wc_cnt_q <= CW'(WRITE_CYCLES - 1);
        stat_pend_q <= go_status;
        prog_addr_q <= addr_q[ADDR_W-1:0];
      end else if (wc_done) begin
        busy_q <= 1'b0;
        stat_pend_q <= 1'b0;
      end else if (busy_q) begin
        wc_cnt_q <= wc_cnt_q - 1'b1;
      end
    end
  end

  // Latch and non-volatile status bits
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wel_q <= 1'b0;
      stat_nv_q <= eeprom_front_pkg::STATUS_RST;
    end else if (wc_done) begin
      wel_q <= 1'b0;
      if (stat_pend_q) stat_nv_q <= stat_new_q & eeprom_front_pkg::STATUS_WR_MASK;
    end else if (end_ok && op_q == eeprom_front_pkg::OP_SET_WEL) begin
      wel_q <= 1'b1;
    end else if (end_ok && op_q == eeprom_front_pkg::OP_CLR_WEL) begin
      wel_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write data buffer toward the array programmer
  byte_fifo #(.W(eeprom_front_pkg::BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rstn(rstn),
    .in_data(rx_byte),
    .in_valid(wdata_byte),
    .in_ready(fifo_in_ready),
    .out_data(wr_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready)
  );

  // Port drive
  assign so_out = so_q;
  assign so_oe_n = oe_n_q;
  assign rd_req = rd_req_q;
  assign rd_addr = addr_q[ADDR_W-1:0];
  assign prog_start = prog_q;
  assign prog_addr = prog_addr_q;
  assign busy = busy_q;
  assign write_latch = wel_q;
  assign status = status_now;
  assign standby = s_cs_n && !busy_q;
  assign overrun = overrun_q;
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_opcode_load: assert property (byte_done && in_opcode |=> op_q == $past(rx_byte))
    else $error("opcode not loaded");
  a_out_on_fall: assert property (so_q != $past(so_q) |-> $past(sck_fall))
    else $error("output changed off falling edge");
  a_deselect_float: assert property (s_cs_n && cs_prev_q |-> so_oe_n ##1 so_oe_n)
    else $error("output driven while deselected");
  a_frame_restart: assert property (cs_fall |=> in_opcode && bit_cnt_q == 3'h0)
    else $error("frame did not restart");
  a_launch_on_rise: assert property ($rose(busy_q) |-> $past(cs_rise))
    else $error("write cycle started off select rise");
  a_wel_set: assert property (end_ok && op_q == eeprom_front_pkg::OP_SET_WEL |=> wel_q)
    else $error("latch not set");
  a_wel_clear: assert property (end_ok && op_q == eeprom_front_pkg::OP_CLR_WEL |=> !wel_q)
    else $error("latch not cleared");
  a_protect_abort: assert property (cs_rise && wp_abort_q && !busy_q |=> !busy_q)
    else $error("protected status write launched");
  a_busy_ignore: assert property (byte_done && in_opcode && busy_q
                   && rx_byte != eeprom_front_pkg::OP_RD_STATUS |=> phase_q == eeprom_front_pkg::PH_IDLE)
    else $error("opcode honoured while busy");
  a_unknown_float: assert property (byte_done && in_opcode && !op_known(rx_byte, busy_q)
                     |=> (oe_n_q && phase_q == eeprom_front_pkg::PH_IDLE)[*4])
    else $error("unknown opcode not ignored");
  a_busy_bit: assert property (launch |=> status[eeprom_front_pkg::ST_BUSY] && !standby
                ##1 status[eeprom_front_pkg::ST_BUSY] && !standby)
    else $error("busy bit wrong");
  c_status_read: cover property (load_status ##[1:200] !oe_n_q);
  c_array_write: cover property (go_array ##1 prog_start);
  c_status_write: cover property (wc_done && stat_pend_q);
  c_wp_abort: cover property (cs_rise && wp_abort_q);
endmodule // spi_eeprom_front

//--- tb/spi_host_model.sv
// Behavioural SPI host that drives the serial link in mode 0
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clock,
  input wire logic so_out,
  input wire logic so_oe_n,
  output logic sck,
  output logic cs_n,
  output logic si
);
  logic last_so;
  logic miso;
  ////////////////////////////////////////////////////////////////////////
  // Released data out line shows the inverse of its last driven bit
  always @(posedge clock) begin
    if (so_oe_n === 1'b0) last_so <= so_out;
  end
  assign miso = (so_oe_n === 1'b0) ? so_out : ~last_so;
  // Link idles deselected, clock still and low
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    last_so = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Select falls before every sequence, then setup time
  task automatic start();
    @(negedge clock);
    cs_n = 1'b0;
    repeat (4) @(negedge clock);
  endtask
  // Shift up to eight bits, MSB first, data set while clock is low
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 8 - nb; i--) begin
      si = tx[i];
      repeat (4) @(negedge clock);
      rx[i] = miso;
      sck = 1'b1;
      repeat (4) @(negedge clock);
      sck = 1'b0;
    end
  endtask
  // Deselect and toggle the data-in line, then wait
  task automatic stop();
    repeat (4) @(negedge clock);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge clock);
  endtask
endmodule // spi_host_model

//--- tb/spi_eeprom_front_tb_top.sv
// Self-checking testbench of the serial EEPROM command front end
`timescale 1ns/100ps
module spi_eeprom_front_tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wp_n = 1'b1;
  logic wr_ready = 1'b0;
  wire sck, cs_n, si, so_out, so_oe_n, rd_req, wr_valid, prog_start;
  wire busy, write_latch, standby, overrun;
  wire [12:0] rd_addr, prog_addr;
  wire [7:0] rd_data, wr_data, status;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_prog = 0;
  int n_rd = 0;
  int n_oe = 0;
  int m, k;
  logic [12:0] pa;
  logic [7:0] r;
  logic [7:0] got[$];
  logic [7:0] popped[$];
  logic [18:0] row;
  ////////////////////////////////////////////////////////////////////////
  always #10 clock = ~clock;
  // Array model answers from the read address
  assign rd_data = rd_addr[7:0] ^ 8'h5A;
  spi_eeprom_front #(.WRITE_CYCLES(1200)) i_spi_eeprom_front (.clock(clock), .rstn(rstn), .sck(sck),
    .cs_n(cs_n), .si(si), .wp_n(wp_n), .so_out(so_out), .so_oe_n(so_oe_n), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_data(rd_data), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .prog_start(prog_start), .prog_addr(prog_addr), .busy(busy), .write_latch(write_latch),
    .status(status), .standby(standby), .overrun(overrun));
  spi_host_model i_spi_host_model (.clock(clock), .so_out(so_out), .so_oe_n(so_oe_n), .sck(sck),
    .cs_n(cs_n), .si(si));
  ////////////////////////////////////////////////////////////////////////
  // Event counters, FIFO drain capture and hang limit
  always @(posedge clock) begin
    if (prog_start === 1'b1) begin
      n_prog++;
      pa = prog_addr;
    end
    if (rd_req === 1'b1) n_rd++;
    if (so_oe_n === 1'b0) n_oe++;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) popped.push_back(wr_data);
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Select and send bytes, keeping what came back
  task automatic frame(input logic [7:0] b[$]);
    logic [7:0] x;
    got = {};
    i_spi_host_model.start();
    foreach (b[i]) begin
      i_spi_host_model.xfer(b[i], 8, x);
      got.push_back(x);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    frame('{op});
    i_spi_host_model.stop();
  endtask
  task automatic read_status_cmd();
    frame('{eeprom_front_pkg::OP_RD_STATUS, 8'h00});
    i_spi_host_model.stop();
  endtask
  // Poll status until the busy bit clears, bounded
  task automatic wait_ready();
    int n = 0;
    read_status_cmd();
    while (got[1][0] !== 1'b0 && n < 20) begin
      read_status_cmd();
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    repeat (4) @(negedge clock);
    check(status, 8'h00);
    check({so_oe_n, standby, busy, write_latch}, 4'hC);
    // Partial byte at deselect is discarded
    i_spi_host_model.start();
    i_spi_host_model.xfer(eeprom_front_pkg::OP_SET_WEL, 7, r);
    i_spi_host_model.stop();
    check(write_latch, 1'b0);
    // Latch set, read back, cleared
    cmd(eeprom_front_pkg::OP_SET_WEL);
    check(write_latch, 1'b1);
    read_status_cmd();
    check(got[1], 8'h02);
    cmd(eeprom_front_pkg::OP_CLR_WEL);
    check(write_latch, 1'b0);
    // Unknown opcode keeps output floating
    m = n_oe;
    frame('{8'hFF, 8'h05, 8'h00});
    i_spi_host_model.stop();
    check(16'(n_oe - m), 16'h0000);
    // Array write refused without latch, or with latch set in the same frame
    frame('{eeprom_front_pkg::OP_SET_WEL, eeprom_front_pkg::OP_WR_ARRAY, 8'h00, 8'h00, 8'h11});
    i_spi_host_model.stop();
    frame('{eeprom_front_pkg::OP_CLR_WEL});
    i_spi_host_model.stop();
    frame('{eeprom_front_pkg::OP_WR_ARRAY, 8'h00, 8'h10, 8'h77});
    i_spi_host_model.stop();
    check({n_prog[3:0], wr_valid}, 5'h00);
    // Array write of nine bytes into a stalled FIFO
    cmd(eeprom_front_pkg::OP_SET_WEL);
    frame('{eeprom_front_pkg::OP_WR_ARRAY, 8'hF2, 8'h34, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15,
            8'h16, 8'h17, 8'h18});
    check({n_prog[3:0], busy}, 5'h00);
    check({overrun, wr_valid}, 2'b11);
    i_spi_host_model.stop();
    check({n_prog[3:0], busy, standby}, 6'h06);
    check(pa, 13'h1234);
    // Only status read honoured during the write cycle
    m = n_oe;
    k = n_rd;
    frame('{eeprom_front_pkg::OP_RD_ARRAY, 8'h00, 8'h00, 8'h00});
    i_spi_host_model.stop();
    check(16'(n_oe - m + n_rd - k), 16'h0000);
    read_status_cmd();
    check(got[1], 8'h03);
    // Drain the FIFO until empty
    wr_ready = 1'b1;
    repeat (20) @(negedge clock);
    check(popped.size(), 8);
    foreach (popped[i]) check(popped[i], 8'h10 + i);
    check(wr_valid, 1'b0);
    wait_ready();
    check({got[1], standby}, 9'h001);
    // Array read across the top of the address space
    k = n_rd;
    frame('{eeprom_front_pkg::OP_RD_ARRAY, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'h00});
    i_spi_host_model.stop();
    check(16'(n_rd - k), 16'h0004);
    for (int i = 0; i < 3; i++) check(got[3 + i], 8'(16'hFFFE + i) ^ 8'h5A);
    check(so_oe_n, 1'b1);
    // Status writes against the protect pin: frame, mid-frame pulse, during cycle
    for (int i = 0; i < 6; i++) begin
      row = (i == 0) ? {3'b101, 8'hFF, 8'h8C} : (i == 1) ? {3'b001, 8'h00, 8'h8C} :
            (i == 2) ? {3'b111, 8'h00, 8'h8C} : (i == 3) ? {3'b100, 8'h80, 8'h80} :
            (i == 4) ? {3'b101, 8'h04, 8'h04} : {3'b000, 8'h08, 8'h08};
      cmd(eeprom_front_pkg::OP_SET_WEL);
      wp_n = row[18];
      frame('{eeprom_front_pkg::OP_WR_STATUS, row[15:8]});
      if (row[17]) begin
        wp_n = 1'b0;
        repeat (8) @(negedge clock);
        wp_n = 1'b1;
      end
      i_spi_host_model.stop();
      wp_n = row[16];
      wait_ready();
      wp_n = 1'b1;
      check(got[1] & 8'hFD, row[7:0]);
    end
    complete_run();
  end
endmodule // spi_eeprom_front_tb_top
